// File: inc/err_status_pkg.sv
// constants for the sticky error status register bank
// assumes a config-space access port on the device clock
// Overview of operation
// - one error message per cycle with any flag rise when per-flag and global enables allow
// - flags other than bit 11 set on their event regardless of message enables
// - flag holds until software writes one to it; that re-arms logging
// - bit 12 sets on graphics software event causing management interrupt
// - bit 11 sets on thermal trip only if a message is sent
// - no thermal message while thermal flag already set
// - later thermal trips while flag set may be dropped, not queued
// - bit 9 sets on locked access not mapping to dram
// - bit 8 sets when pending refresh count reaches 1024
// - bit 7 sets on dram throttling; reads 0 only after software clear
// - system errors go out as link messages, no dedicated pin
// - command enables at bits 12,11,9,8,7 gate the error message of the same-position flag
package err_status_pkg;
   localparam logic [7:0]  ERROR_STATUS_OFFSET = 8'hc8;
   localparam logic [15:0] ERROR_STATUS_RESET  = 16'h0000;
   localparam int          SWEVT_BIT           = 12;
   localparam int          THERMAL_BIT         = 11;
   localparam int          LOCK_BIT            = 9;
   localparam int          REFRESH_BIT         = 8;
   localparam int          THROTTLE_BIT        = 7;
   localparam logic [15:0] ERROR_STATUS_MASK   = 16'h1b80;
   localparam logic [10:0] REFRESH_TIMEOUT_CNT = 11'h400;
endpackage : err_status_pkg

// File: design/rise_detect.sv
// rising-edge detector for one flag, same clock domain
// assumes input is already synchronous to sys_clk
`timescale 1ns/10ps
module rise_detect (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic level,
   output logic      rise
);
   logic level_q;

   // remember last value
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level;
      end
   end

   assign rise = level & ~level_q;
endmodule : rise_detect

// File: design/error_status_flags.sv
// sticky error status register with error message generation
// assumes event inputs are one-cycle pulses on sys_clk and a
// config access port at byte offset error_status_offset
`timescale 1ns/10ps
module error_status_flags (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [15:0] cfg_wdata,
   output logic [15:0]      cfg_rdata,
   input  wire logic [15:0] error_command_enables,
   input  wire logic        pci_serr_enable,
   input  wire logic        gfx_sw_smi_event,
   input  wire logic        thermal_trip,
   input  wire logic        thermal_msg_enable,
   input  wire logic        nondram_lock_event,
   input  wire logic        refresh_enqueue,
   input  wire logic        refresh_dequeue,
   input  wire logic        dram_throttle_event,
   output logic             serr_msg,
   output logic             thermal_msg,
   output logic [15:0]      error_status
);
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic [10:0] refresh_cnt_q;
   logic        refresh_hit;
   logic        thermal_send;
   logic [15:0] rise_vec;
   logic        serr_q;
   logic        thermal_msg_q;
   logic [15:0] rdata_q;

   // thermal message only while flag clear; extra trips dropped
   assign thermal_send = thermal_trip & thermal_msg_enable
                       & ~status_q[err_status_pkg::THERMAL_BIT];

   // pending refresh counter, saturating at the timeout level
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         refresh_cnt_q <= 11'h000;
      end else if (refresh_enqueue && !refresh_dequeue &&
                   refresh_cnt_q != err_status_pkg::REFRESH_TIMEOUT_CNT) begin
         refresh_cnt_q <= refresh_cnt_q + 11'h001;
      end else if (refresh_dequeue && !refresh_enqueue && refresh_cnt_q != 11'h000) begin
         refresh_cnt_q <= refresh_cnt_q - 11'h001;
      end
   end
   assign refresh_hit = (refresh_cnt_q == err_status_pkg::REFRESH_TIMEOUT_CNT);

   // event set vector, independent of enables except thermal_msg_enable on the thermal bit
   always_comb begin
      set_vec = 16'h0000;
      set_vec[err_status_pkg::SWEVT_BIT]    = gfx_sw_smi_event;
      set_vec[err_status_pkg::THERMAL_BIT]  = thermal_send;
      set_vec[err_status_pkg::LOCK_BIT]     = nondram_lock_event;
      set_vec[err_status_pkg::REFRESH_BIT]  = refresh_hit;
      set_vec[err_status_pkg::THROTTLE_BIT] = dram_throttle_event;
   end

   // write-one-to-clear on reserved-masked bits
   assign clr_vec = (cfg_wr && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET)
                    ? (cfg_wdata & err_status_pkg::ERROR_STATUS_MASK) : 16'h0000;

   // set wins over clear in the same cycle
   assign status_d = ((status_q & ~clr_vec) | set_vec) & err_status_pkg::ERROR_STATUS_MASK;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         status_q <= err_status_pkg::ERROR_STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // one detector per status bit, all 16 including reserved bits
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_rise
         rise_detect u_rise (
            .sys_clk (sys_clk),
            .nrst    (nrst),
            .level   (status_q[gi]),
            .rise    (rise_vec[gi])
         );
      end
   endgenerate

   // error message pulse on a gated flag rise, sent over the link
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         serr_q <= 1'b0;
      end else begin
         serr_q <= pci_serr_enable &
                   (|(rise_vec & error_command_enables & err_status_pkg::ERROR_STATUS_MASK));
      end
   end

   // thermal interrupt message, aligned with flag set
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         thermal_msg_q <= 1'b0;
      end else begin
         thermal_msg_q <= thermal_send;
      end
   end

   // read data register
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
      end else if (cfg_rd && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET) begin
         rdata_q <= status_q;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign cfg_rdata    = rdata_q;
   assign serr_msg     = serr_q;
   assign thermal_msg  = thermal_msg_q;
   assign error_status = status_q;

   // message goes out one cycle after a gated flag rise
   a_serr_on_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
      (status_q[err_status_pkg::LOCK_BIT] && !$past(status_q[err_status_pkg::LOCK_BIT])
       && error_command_enables[err_status_pkg::LOCK_BIT] && pci_serr_enable)
      |=> serr_msg)
      else $error("missing error message");
   a_serr_thermal: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($rose(status_q[err_status_pkg::THERMAL_BIT]) && error_command_enables[err_status_pkg::THERMAL_BIT]
       && pci_serr_enable) |=> serr_msg)
      else $error("missing thermal error message");
   a_serr_refresh: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($rose(status_q[err_status_pkg::REFRESH_BIT]) && error_command_enables[err_status_pkg::REFRESH_BIT]
       && pci_serr_enable) |=> serr_msg)
      else $error("missing refresh error message");
   a_serr_throttle: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($rose(status_q[err_status_pkg::THROTTLE_BIT]) && error_command_enables[err_status_pkg::THROTTLE_BIT]
       && pci_serr_enable) |=> serr_msg)
      else $error("missing throttle error message");

   // no message without the global enable and a gated rise
   a_no_global: assert property (@(posedge sys_clk) disable iff (!nrst)
      !pci_serr_enable |=> !serr_msg)
      else $error("message without global enable");
   a_serr_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      serr_msg |-> $past(pci_serr_enable)
      && (|($past(status_q) & ~$past(status_q, 2) & $past(error_command_enables)
            & err_status_pkg::ERROR_STATUS_MASK)))
      else $error("message without flag rise");

   // each event sets its flag whatever the enables
   a_lock_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      nondram_lock_event |=> status_q[err_status_pkg::LOCK_BIT])
      else $error("lock flag not set");
   a_swevt_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      gfx_sw_smi_event |=> status_q[err_status_pkg::SWEVT_BIT])
      else $error("sw flag not set");
   a_throttle_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      dram_throttle_event |=> status_q[err_status_pkg::THROTTLE_BIT])
      else $error("throttle flag");
   a_refresh_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      (refresh_cnt_q == err_status_pkg::REFRESH_TIMEOUT_CNT) |=> status_q[err_status_pkg::REFRESH_BIT])
      else $error("refresh flag");

   // a flag only rises after its own cause
   a_lock_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(status_q[err_status_pkg::LOCK_BIT]) |-> $past(nondram_lock_event))
      else $error("lock flag without event");
   a_swevt_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(status_q[err_status_pkg::SWEVT_BIT]) |-> $past(gfx_sw_smi_event))
      else $error("sw flag without event");
   a_throttle_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(status_q[err_status_pkg::THROTTLE_BIT]) |-> $past(dram_throttle_event))
      else $error("throttle flag without event");
   a_refresh_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(status_q[err_status_pkg::REFRESH_BIT])
      |-> $past(refresh_cnt_q == err_status_pkg::REFRESH_TIMEOUT_CNT))
      else $error("refresh flag below limit");

   // thermal flag and message follow an enabled trip while clear
   a_thermal_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      status_q[err_status_pkg::THERMAL_BIT] |=> !thermal_msg)
      else $error("thermal msg while set");
   a_thermal_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!$past(status_q[err_status_pkg::THERMAL_BIT]) && status_q[err_status_pkg::THERMAL_BIT])
      |-> thermal_msg)
      else $error("thermal flag without message");
   a_thermal_enable: assert property (@(posedge sys_clk) disable iff (!nrst)
      thermal_msg |-> $past(thermal_trip && thermal_msg_enable
                            && !status_q[err_status_pkg::THERMAL_BIT]))
      else $error("thermal message without enabled trip");
   a_thermal_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      (thermal_trip && thermal_msg_enable && !status_q[err_status_pkg::THERMAL_BIT])
      |=> (status_q[err_status_pkg::THERMAL_BIT] && thermal_msg))
      else $error("enabled trip not logged");
   a_thermal_refused: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!status_q[err_status_pkg::THERMAL_BIT] && !(thermal_trip && thermal_msg_enable))
      |=> !status_q[err_status_pkg::THERMAL_BIT])
      else $error("thermal flag without enabled trip");

   // write one to clear, otherwise flags hold
   a_sticky_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (status_q[err_status_pkg::THROTTLE_BIT] && !clr_vec[err_status_pkg::THROTTLE_BIT])
      |=> status_q[err_status_pkg::THROTTLE_BIT])
      else $error("flag lost");
   a_w1c_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clr_vec[err_status_pkg::SWEVT_BIT] && !gfx_sw_smi_event)
      |=> !status_q[err_status_pkg::SWEVT_BIT])
      else $error("clear failed");
   a_lock_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cfg_wr && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET
       && cfg_wdata[err_status_pkg::LOCK_BIT] && !nondram_lock_event)
      |=> !status_q[err_status_pkg::LOCK_BIT])
      else $error("lock flag not cleared");
   a_other_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cfg_wr && cfg_addr != err_status_pkg::ERROR_STATUS_OFFSET && status_q[err_status_pkg::LOCK_BIT])
      |=> status_q[err_status_pkg::LOCK_BIT])
      else $error("flag cleared by other address");

   // reserved bits stay zero, read data shows the flags
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
      (status_q & ~err_status_pkg::ERROR_STATUS_MASK) == 16'h0000)
      else $error("reserved bit set");
   a_rdata_value: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cfg_rd && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET) |=> cfg_rdata == $past(status_q))
      else $error("read data differs from flags");
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(cfg_rd && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET) |=> cfg_rdata == 16'h0000)
      else $error("read data outside a read");

   // pending refresh counter never passes the timeout level
   a_refresh_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
      refresh_cnt_q <= err_status_pkg::REFRESH_TIMEOUT_CNT)
      else $error("refresh count above limit");
   a_refresh_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (refresh_cnt_q == err_status_pkg::REFRESH_TIMEOUT_CNT && !refresh_dequeue)
      |=> refresh_cnt_q == err_status_pkg::REFRESH_TIMEOUT_CNT)
      else $error("refresh count left the limit");
endmodule : error_status_flags

// File: test/host_model.sv
// host software model: random config reads and writes
// assumes the status register sits at the package offset
`timescale 1ns/10ps
module host_model (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   output logic [7:0]       cfg_addr,
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic [15:0]      cfg_wdata
);
   integer     seed = 32'h0f332976;
   logic [31:0] r;
   initial {cfg_addr, cfg_wr, cfg_rd, cfg_wdata} = '0;
   // one-cycle strobes, mostly at the status offset
   always @(negedge sys_clk) begin
      r = $random(seed);
      cfg_wr <= nrst && r[3:0] == 4'h0;
      cfg_rd <= nrst && r[5:4] == 2'h0;
      cfg_addr <= r[7:6] == 2'h0 ? r[15:8] : err_status_pkg::ERROR_STATUS_OFFSET;
      cfg_wdata <= r[31:16];
   end
endmodule : host_model

// File: test/tb.sv
// self-checking bench for the error status flags
// assumes host_model drives the config port
`timescale 1ns/10ps
module tb;
   logic sys_clk = 0, nrst = 0, pci_serr_enable = 0, gfx_sw_smi_event = 0, thermal_trip = 0;
   logic thermal_msg_enable = 0, nondram_lock_event = 0, refresh_enqueue = 0, refresh_dequeue = 0;
   logic dram_throttle_event = 0, cfg_wr, cfg_rd, serr_msg, thermal_msg;
   logic [15:0] error_command_enables = '0, cfg_wdata, cfg_rdata, error_status, f, fp, exp_rd;
   logic [7:0]  cfg_addr;
   logic        exp_serr, exp_therm, quiet;
   logic [31:0] r;
   integer      seed = 32'h0f332976, cnt, n_mismatch = 0, compares = 0;
   always #5 sys_clk = ~sys_clk;
   host_model i_host (.sys_clk(sys_clk), .nrst(nrst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata));
   error_status_flags i_dut (.sys_clk(sys_clk), .nrst(nrst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .error_command_enables(error_command_enables), .pci_serr_enable(pci_serr_enable),
      .gfx_sw_smi_event(gfx_sw_smi_event), .thermal_trip(thermal_trip),
      .thermal_msg_enable(thermal_msg_enable), .nondram_lock_event(nondram_lock_event),
      .refresh_enqueue(refresh_enqueue), .refresh_dequeue(refresh_dequeue),
      .dram_throttle_event(dram_throttle_event), .serr_msg(serr_msg), .thermal_msg(thermal_msg),
      .error_status(error_status));
   // reference model of flags, messages and read data
   always @(posedge sys_clk) begin
      if (!nrst) begin
         {f, fp, exp_rd, exp_serr, exp_therm} = '0;
         cnt = 0;
      end else begin
         exp_serr = pci_serr_enable && |(f & ~fp & error_command_enables & 16'h1b80);
         exp_rd = (cfg_rd && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET) ? f : 16'h0000;
         exp_therm = thermal_trip && thermal_msg_enable && !f[11];
         fp = f;
         if (cfg_wr && cfg_addr == err_status_pkg::ERROR_STATUS_OFFSET) f = f & ~(cfg_wdata & 16'h1b80);
         if (cnt == 1024) f[8] = 1'b1;
         if (refresh_enqueue && !refresh_dequeue && cnt < 1024) cnt = cnt + 1;
         else if (refresh_dequeue && !refresh_enqueue && cnt > 0) cnt = cnt - 1;
         f = f | {3'h0, gfx_sw_smi_event, exp_therm, 1'b0, nondram_lock_event, 1'b0, dram_throttle_event, 7'h00};
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares = compares + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic final_report;
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   // compare outputs against the model before new stimulus
   always @(negedge sys_clk) begin
      if (nrst) begin
         chk(error_status, f, "flags");
         chk({15'h0, serr_msg}, {15'h0, exp_serr}, "serr");
         chk({15'h0, thermal_msg}, {15'h0, exp_therm}, "thermal");
         chk(cfg_rdata, exp_rd, "rdata");
      end
   end
   // random sparse events; command and global enables change only in quiet windows, thermal_msg_enable every cycle
   initial begin
      repeat (20) @(negedge sys_clk);
      nrst <= 1'b1;
      for (int cyc = 0; cyc < 4000; cyc++) begin
         @(negedge sys_clk);
         r = $random(seed);
         quiet = (cyc + 2) % 64 < 4;
         nrst <= !(cyc >= 1000 && cyc < 1003);
         if (cyc % 64 == 0) error_command_enables <= 16'($random(seed));
         if (cyc % 64 == 0) pci_serr_enable <= r[31];
         gfx_sw_smi_event <= !quiet && r[2:0] == 3'h0;
         thermal_trip <= !quiet && r[5:3] == 3'h0;
         thermal_msg_enable <= r[12];
         nondram_lock_event <= !quiet && r[8:6] == 3'h0;
         dram_throttle_event <= !quiet && r[11:9] == 3'h0;
         refresh_enqueue <= cyc >= 1500 && cyc < 2600;
         refresh_dequeue <= cyc >= 3200 && r[14:13] == 2'h0;
      end
      final_report();
   end
endmodule : tb
